// ===== core/gpt_timer.sv
// gated period timer with level-reset one-shot modes and a pulse output
// assumes CLOCK_IN at 125 MHz; gate input is asynchronous and synchronised here
//
// Chosen here: the address map and the plain strobed port.
`default_nettype none
module gpt_timer #(
	parameter int DUTY_W = 10
) (
	// clock and reset
	input  wire logic        CLOCK_IN,
	input  wire logic        RESET_IN,
	// register port
	input  wire logic [3:0]  ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [7:0]  RDATA_OUT,
	// external gate / reset input, asynchronous
	input  wire logic        GATE_RESET_IN,
	// pulse pin
	output logic             PULSE_OUT
);
	gpt_pkg::gpt_bus_s bus;
	assign bus.wr    = WR_IN;
	assign bus.rd    = RD_IN;
	assign bus.addr  = ADDR_IN;
	assign bus.wdata = WDATA_IN;

	////////////////////////////////////////////////////////////////
	// registers
	logic       enable_r;
	logic       polarity_r;
	logic       run_r;
	logic [4:0] mode_r;
	logic [7:0] period_r;
	logic [7:0] duty_h_r;
	logic [1:0] duty_l_r;
	logic [7:0] count_r;
	logic       active_r;
	logic [7:0] rdata_r;
	logic       gate_s1_r;
	logic       gate_s2_r;
	logic       gate_d_r;

	// write strobe aimed at one register offset
	function automatic logic addr_wr(input gpt_pkg::gpt_bus_s b, input logic [3:0] ofs);
		return b.wr && (b.addr == ofs);
	endfunction

	wire wr_ctrl   = addr_wr(bus, gpt_pkg::OFS_CTRL);
	wire wr_tcon   = addr_wr(bus, gpt_pkg::OFS_TCON);
	wire wr_period = addr_wr(bus, gpt_pkg::OFS_PERIOD);
	wire wr_duty_h = addr_wr(bus, gpt_pkg::OFS_DUTY_H);
	wire wr_duty_l = addr_wr(bus, gpt_pkg::OFS_DUTY_L);
	wire wr_mode   = addr_wr(bus, gpt_pkg::OFS_MODE);

	////////////////////////////////////////////////////////////////
	// gate synchroniser and mode decode
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			gate_s1_r <= 1'b0;
			gate_s2_r <= 1'b0;
			gate_d_r  <= 1'b0;
		end else begin
			gate_s1_r <= GATE_RESET_IN;
			gate_s2_r <= gate_s1_r;
			gate_d_r  <= gate_s2_r;
		end
	end

	wire gate = gate_s2_r;
	wire is_gate_hi = mode_r == gpt_pkg::MODE_GATE_HIGH;
	wire is_gate_lo = mode_r == gpt_pkg::MODE_GATE_LOW;
	wire is_os_lo   = mode_r == gpt_pkg::MODE_OS_LOW;
	wire is_os_hi   = mode_r == gpt_pkg::MODE_OS_HIGH;
	wire one_shot   = is_os_lo || is_os_hi;
	// pause: hardware gate modes otherwise behave as software gate
	wire paused     = (is_gate_hi && gate) || (is_gate_lo && !gate);
	wire at_reset_lvl = (is_os_lo && !gate) || (is_os_hi && gate);
	wire start_edge = (is_os_lo && gate && !gate_d_r)
	                || (is_os_hi && !gate && gate_d_r);
	// armed: counting allowed in one-shot only after a fresh edge
	logic armed_r;
	wire  match     = count_r == period_r;
	wire  [DUTY_W-1:0] duty = {duty_h_r, duty_l_r};
	// count is 8 bits; duty compares on its upper bits
	wire  duty_hit  = {count_r, 2'b00} >= duty;
	wire  counting  = run_r && !paused && (!one_shot || armed_r);
	wire  os_match  = one_shot && counting && match;

	////////////////////////////////////////////////////////////////
	// register writes and timer
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			enable_r   <= 1'b0;
			polarity_r <= 1'b0;
			run_r      <= 1'b0;
			mode_r     <= gpt_pkg::RST_MODE;
			period_r   <= gpt_pkg::RST_BYTE;
			duty_h_r   <= gpt_pkg::RST_BYTE;
			duty_l_r   <= 2'b00;
		end else begin
			if (wr_ctrl) begin
				enable_r   <= bus.wdata[gpt_pkg::BIT_ENABLE];
				polarity_r <= bus.wdata[gpt_pkg::BIT_POLARITY];
			end
			if (os_match)
				run_r <= 1'b0;
			else if (wr_tcon)
				run_r <= bus.wdata[gpt_pkg::BIT_RUN];
			if (wr_mode)
				mode_r <= bus.wdata[4:0];
			if (wr_period)
				period_r <= bus.wdata;
			if (wr_duty_h)
				duty_h_r <= bus.wdata;
			if (wr_duty_l)
				duty_l_r <= bus.wdata[7:6];
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			armed_r <= 1'b0;
		end else if (!one_shot || !run_r || os_match) begin
			armed_r <= 1'b0;
		end else if (start_edge) begin
			armed_r <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			count_r <= gpt_pkg::RST_BYTE;
		end else if (one_shot && at_reset_lvl) begin
			count_r <= gpt_pkg::RST_BYTE;
		end else if (counting) begin
			count_r <= match ? gpt_pkg::RST_BYTE : count_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////
	// pulse stage; pause freezes count, so both phases stretch
	logic active_nxt;
	always_comb begin
		active_nxt = active_r;
		if (one_shot) begin
			if (run_r && start_edge)
				active_nxt = 1'b1;
			else if (armed_r && duty_hit)
				active_nxt = 1'b0;
		end else if (counting) begin
			if (match)
				active_nxt = duty != '0;
			else if ({count_r + 8'h01, 2'b00} >= duty)
				active_nxt = 1'b0;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN)
			active_r <= 1'b0;
		else
			active_r <= active_nxt;
	end

	// disabled output sits at the polarity level
	wire pulse_lvl = enable_r ? (active_r ^ polarity_r) : polarity_r;
	assign PULSE_OUT = pulse_lvl;

	////////////////////////////////////////////////////////////////
	// read port
	wire [7:0] ctrl_rd = {enable_r, 1'b0, pulse_lvl, polarity_r, 4'h0};
	always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			rdata_r <= gpt_pkg::RST_BYTE;
		end else if (bus.rd) begin
			unique case (bus.addr)
				gpt_pkg::OFS_CTRL:   rdata_r <= ctrl_rd;
				gpt_pkg::OFS_TCON:   rdata_r <= {run_r, 7'h00};
				gpt_pkg::OFS_PERIOD: rdata_r <= period_r;
				gpt_pkg::OFS_DUTY_H: rdata_r <= duty_h_r;
				gpt_pkg::OFS_DUTY_L: rdata_r <= {duty_l_r, 6'h00};
				gpt_pkg::OFS_COUNT:  rdata_r <= count_r;
				gpt_pkg::OFS_MODE:   rdata_r <= {3'h0, mode_r};
				default:             rdata_r <= 8'h00;
			endcase
		end else begin
			rdata_r <= 8'h00;
		end
	end
	assign RDATA_OUT = rdata_r;

	////////////////////////////////////////////////////////////////
	// checks
	chk_gate_hi_hold: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(is_gate_hi && gate && !wr_mode) |=> $stable(count_r))
		else $error("count moved while gated high");
	chk_gate_lo_hold: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(is_gate_lo && !gate && !wr_mode) |=> $stable(count_r))
		else $error("count moved while gated low");
	chk_os_reset_clear: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && at_reset_lvl) |=> count_r == 8'h00)
		else $error("count not cleared at reset level");
	chk_os_match_stop: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		os_match |=> (!run_r && count_r == 8'h00))
		else $error("one-shot match did not stop timer");
	chk_os_no_restart: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && !armed_r && !start_edge) |=> !armed_r)
		else $error("one-shot armed without edge");
	chk_os_start_act: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && run_r && start_edge && !wr_mode) |=> active_r)
		else $error("pulse not active on start edge");
	chk_idle_level: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!enable_r |-> PULSE_OUT == polarity_r)
		else $error("output not idle while disabled");
	chk_count_step: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(counting && !match && !(one_shot && at_reset_lvl) && !wr_mode)
			|=> count_r == $past(count_r) + 8'h01)
		else $error("count did not step by one");
	chk_ctrl_readback: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(bus.rd && bus.addr == gpt_pkg::OFS_CTRL)
			|=> (RDATA_OUT[5] == $past(pulse_lvl) && RDATA_OUT[6] == 1'b0
			&& RDATA_OUT[3:0] == 4'h0))
		else $error("control readback wrong");

	////////////////////////////////////////////////////////////////
	// checks: gating and pause
	// a pause must freeze both phases, or gated pulses come out short
	chk_pause_act_hold: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(paused && !wr_mode)
		|=> $stable(active_r))
		else $error("pulse phase moved while paused");

	chk_pause_cnt_hold: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(paused && !wr_mode)
		|=> $stable(count_r))
		else $error("count moved while paused");

	chk_hw_gate_open: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(run_r && (is_gate_hi || is_gate_lo) && !paused)
		|-> counting)
		else $error("open gate did not count");

	chk_sw_gate_run: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(run_r && mode_r == gpt_pkg::MODE_SW_GATE)
		|-> counting)
		else $error("software gate mode did not count");

	////////////////////////////////////////////////////////////////
	// checks: one-shot start and stop
	chk_os_edge_arm: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && run_r && start_edge && !os_match && !wr_mode)
		|=> armed_r)
		else $error("start edge did not arm timer");

	chk_os_wait_zero: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && !armed_r && count_r == 8'h00)
		|=> count_r == 8'h00)
		else $error("one-shot counted before its edge");

	chk_os_run_disarm: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && !run_r)
		|=> !armed_r)
		else $error("timer armed with run clear");

	chk_os_stop_count: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && !run_r && !at_reset_lvl)
		|=> $stable(count_r))
		else $error("stopped one-shot count moved");

	chk_run_match_wins: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(os_match && wr_tcon)
		|=> !run_r)
		else $error("software write beat period match");

	////////////////////////////////////////////////////////////////
	// checks: one-shot pulse
	chk_os_duty_off: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && armed_r && duty_hit && !(run_r && start_edge))
		|=> !active_r)
		else $error("one-shot pulse not ended at duty");

	chk_os_match_quiet: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(os_match && !active_r && !start_edge)
		|=> !active_r)
		else $error("pulse reactivated on period match");

	chk_os_stay_idle: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(one_shot && !run_r && !active_r)
		|=> !active_r)
		else $error("pulse went active without a start");

	////////////////////////////////////////////////////////////////
	// checks: standard pulse
	chk_std_restart_act: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(!one_shot && counting && match && duty != '0)
		|=> active_r)
		else $error("active phase not begun at restart");

	chk_active_level: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		enable_r
		|-> PULSE_OUT == (active_r ^ polarity_r))
		else $error("pin level disagrees with polarity");

	////////////////////////////////////////////////////////////////
	// checks: register side
	chk_enable_write: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		wr_ctrl
		|=> enable_r == $past(bus.wdata[gpt_pkg::BIT_ENABLE]))
		else $error("enable bit not written");

	chk_polarity_write: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		wr_ctrl
		|=> polarity_r == $past(bus.wdata[gpt_pkg::BIT_POLARITY]))
		else $error("polarity bit not written");

	chk_duty_low_write: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		wr_duty_l
		|=> duty_l_r == $past(bus.wdata[7:6]))
		else $error("duty low bits not written");

	chk_duty_high_write: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		wr_duty_h
		|=> duty_h_r == $past(bus.wdata))
		else $error("duty high byte not written");

	chk_ctrl_fields_rd: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(bus.rd && bus.addr == gpt_pkg::OFS_CTRL)
		|=> (RDATA_OUT[7] == $past(enable_r) && RDATA_OUT[4] == $past(polarity_r)))
		else $error("control field readback wrong");

	chk_tcon_readback: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(bus.rd && bus.addr == gpt_pkg::OFS_TCON)
		|=> RDATA_OUT == {$past(run_r), 7'h00})
		else $error("run bit readback wrong");

	chk_count_readback: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		(bus.rd && bus.addr == gpt_pkg::OFS_COUNT)
		|=> RDATA_OUT == $past(count_r))
		else $error("count readback wrong");

	// read data stands one cycle only, so stale bytes never linger
	chk_rdata_idle: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!bus.rd
		|=> RDATA_OUT == 8'h00)
		else $error("read data not cleared");
endmodule : gpt_timer
`default_nettype wire

// ===== core/gpt_pkg.sv
// package for the gated one-shot timer with pulse output
// assumes a single clock domain and 8-bit register port
`default_nettype none
package gpt_pkg;
	// register offsets (byte addresses on the plain register port)
	localparam logic [3:0] OFS_CTRL    = 4'h0;
	localparam logic [3:0] OFS_TCON    = 4'h1;
	localparam logic [3:0] OFS_PERIOD  = 4'h2;
	localparam logic [3:0] OFS_DUTY_H  = 4'h3;
	localparam logic [3:0] OFS_DUTY_L  = 4'h4;
	localparam logic [3:0] OFS_COUNT   = 4'h5;
	localparam logic [3:0] OFS_MODE    = 4'h6;
	// control register fields
	localparam int BIT_ENABLE   = 7;
	localparam int BIT_LEVEL    = 5;
	localparam int BIT_POLARITY = 4;
	// timer control fields
	localparam int BIT_RUN      = 7;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [4:0] RST_MODE = 5'h00;
	// timer mode codes
	localparam logic [4:0] MODE_SW_GATE   = 5'h00;
	localparam logic [4:0] MODE_GATE_HIGH = 5'h01;
	localparam logic [4:0] MODE_GATE_LOW  = 5'h02;
	localparam logic [4:0] MODE_OS_LOW    = 5'h0E;
	localparam logic [4:0] MODE_OS_HIGH   = 5'h0F;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} gpt_bus_s;
endpackage : gpt_pkg
`default_nettype wire

// ===== verif/gpt_gate_src.sv
// partner model: external gate/reset signal source
// assumes the bench commands the level; it changes only after a clock edge
`default_nettype none
module gpt_gate_src (
	// clock
	input  wire logic clk_in,
	// commanded level
	input  wire logic level_in,
	// gate pin
	output var logic  gate_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial gate_out = 1'b0;
	// launched off the edge so the pin is never sampled mid-change
	always @(posedge clk_in) begin
		gate_out <= level_in;
	end
endmodule // gpt_gate_src
`default_nettype wire

// ===== verif/gpt_timer_tb_top.sv
// bench for the gated one-shot timer with pulse output
// assumes CLOCK_IN at 125 MHz and the register map of gpt_pkg
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module gpt_timer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst, wr, rd, pin, lvl, pulse;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, d, a, b;
	int         fail_count, checks;
	gpt_timer gpt_timer_i (.CLOCK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .GATE_RESET_IN(pin), .PULSE_OUT(pulse));
	gpt_gate_src gpt_gate_src_i (.clk_in(clk), .level_in(lvl), .gate_out(pin));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wreg(input logic [3:0] ad, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1; addr <= ad; wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] ad, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1; addr <= ad;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// bounded wait for a pin level; running out counts as a mismatch
	task automatic wait_pulse(input logic v);
		int i;
		// sampled 1 ns past the edge; a wrap from a high count may take 256 cycles
		#1;
		for (i = 0; i < 300 && pulse !== v; i++) begin
			@(posedge clk);
			#1;
		end
		`CHK(pulse, v)
		if (pulse !== v) stop_test();
	endtask
	task automatic wait_run_clear();
		int i;
		d = 8'hFF;
		for (i = 0; i < 60 && d[7] !== 1'b0; i++) rreg(gpt_pkg::OFS_TCON, d);
		`CHK(d[7], 1'b0)
		if (d[7] !== 1'b0) stop_test();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1; wr = 1'b0; rd = 1'b0; lvl = 1'b0; addr = 4'h0; wdata = 8'h00;
		fail_count = 0; checks = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// control register
		rreg(gpt_pkg::OFS_CTRL, d);
		`CHK(d, 8'h00)
		wreg(gpt_pkg::OFS_CTRL, 8'hFF);
		rreg(gpt_pkg::OFS_CTRL, d);
		`CHK(d, 8'hB0)
		`CHK(pulse, 1'b1)
		wreg(gpt_pkg::OFS_CTRL, 8'h00);
		#1 `CHK(pulse, 1'b0)
		wreg(gpt_pkg::OFS_DUTY_L, 8'hFF);
		rreg(gpt_pkg::OFS_DUTY_L, d);
		`CHK(d, 8'hC0)
		rreg(4'hF, d);
		`CHK(d, 8'h00)
		$display("test control done");
		// hardware gating, both senses
		wreg(gpt_pkg::OFS_PERIOD, 8'hFF);
		lvl <= 1'b1;
		wreg(gpt_pkg::OFS_MODE, {3'h0, gpt_pkg::MODE_GATE_HIGH});
		wreg(gpt_pkg::OFS_TCON, 8'h80);
		repeat (4) @(posedge clk);
		rreg(gpt_pkg::OFS_COUNT, a);
		repeat (5) @(posedge clk);
		rreg(gpt_pkg::OFS_COUNT, b);
		`CHK(b, a)
		lvl <= 1'b0;
		repeat (5) @(posedge clk);
		rreg(gpt_pkg::OFS_COUNT, b);
		`CHK(b !== a, 1'b1)
		wreg(gpt_pkg::OFS_MODE, {3'h0, gpt_pkg::MODE_GATE_LOW});
		rreg(gpt_pkg::OFS_COUNT, a);
		repeat (5) @(posedge clk);
		rreg(gpt_pkg::OFS_COUNT, b);
		`CHK(b, a)
		$display("test gating done");
		// standard mode: period 4 counts, duty 4 quarter-steps
		wreg(gpt_pkg::OFS_MODE, {3'h0, gpt_pkg::MODE_SW_GATE});
		wreg(gpt_pkg::OFS_PERIOD, 8'h03);
		wreg(gpt_pkg::OFS_DUTY_H, 8'h01);
		wreg(gpt_pkg::OFS_DUTY_L, 8'h00);
		wreg(gpt_pkg::OFS_CTRL, 8'h80);
		wait_pulse(1'b1);
		wait_pulse(1'b0);
		wreg(gpt_pkg::OFS_TCON, 8'h00);
		$display("test standard done");
		// one-shot, low then high reset level
		for (int k = 0; k < 2; k++) begin
			lvl <= k[0];
			wreg(gpt_pkg::OFS_MODE, {3'h0, k[0] ? gpt_pkg::MODE_OS_HIGH : gpt_pkg::MODE_OS_LOW});
			wreg(gpt_pkg::OFS_PERIOD, 8'h10);
			wreg(gpt_pkg::OFS_DUTY_H, 8'h02);
			wreg(gpt_pkg::OFS_TCON, 8'h80);
			repeat (6) @(posedge clk);
			rreg(gpt_pkg::OFS_COUNT, d);
			`CHK(d, 8'h00)
			lvl <= ~k[0];
			wait_pulse(1'b1);
			wait_pulse(1'b0);
			wait_run_clear();
			`CHK(pulse, 1'b0)
			wreg(gpt_pkg::OFS_TCON, 8'h80);
			repeat (6) @(posedge clk);
			rreg(gpt_pkg::OFS_COUNT, d);
			`CHK(d, 8'h00)
			`CHK(pulse, 1'b0)
			wreg(gpt_pkg::OFS_TCON, 8'h00);
			$display("test one-shot %0d done", k);
		end
		stop_test();
	end
endmodule // gpt_timer_tb_top
`default_nettype wire
